/* File: verification/tb_window_watchdog_supervisor_timing.sv */
// bench: host and supervisor joined by the link, driven over registers
// assumes shortened supervisor counts set below
`default_nettype none
module tb_window_watchdog_supervisor_timing
    import wwd_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CW = 20;
    localparam int DL = 30;
    localparam int ST = 10;
    logic clock;
    logic reset_n;
    logic undervoltage;
    logic [3:0] address;
    logic [7:0] write_data;
    logic write_strobe;
    logic read_strobe;
    logic [7:0] read_data;
    logic irq;
    logic early_fault;
    logic late_fault;
    logic [31:0] lfsr_r;
    int fails;
    int n_compared;
    int n_early;
    int n_late;
    wwd_link_if link_if();
    wwd_supervisor #(.CLOSED_CYCLES(CW), .DELAY_CYCLES(DL), .START_CYCLES(ST), .UV_CYCLES(5),
        .EN_HOLD_CYCLES(8), .SEL_HOLD_CYCLES(8)) wwd_supervisor_inst (.clock(clock),
        .reset_n(reset_n), .undervoltage(undervoltage), .link(link_if),
        .early_fault(early_fault), .late_fault(late_fault));
    wwd_host wwd_host_inst (.clock(clock), .reset_n(reset_n), .link(link_if),
        .address(address), .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data), .irq(irq));
    wwd_chk #(.DELAY_CYCLES(DL), .START_CYCLES(ST), .UV_CYCLES(5),
        .KICK_CYCLES(KICK_PULSE_CYCLES), .MR_CYCLES(MR_PULSE_CYCLES)) wwd_chk_inst (
        .clock(clock), .reset_n(reset_n), .undervoltage(undervoltage),
        .kick_input(link_if.kick_input), .watchdog_enable(link_if.watchdog_enable),
        .manual_reset_n(link_if.manual_reset_n), .reset_out_n(link_if.reset_out_n),
        .fault_output_n(link_if.fault_output_n), .early_fault(early_fault),
        .late_fault(late_fault));
    always #25 clock = ~clock;
    always @(posedge clock) begin
        if (early_fault === 1'b1) n_early <= n_early + 1;
        if (late_fault === 1'b1) n_late <= n_late + 1;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic int open_len(input int s);
        return CW * ((2 << s) - 1);
    endfunction : open_len
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        chk(name, exp, read_data);
        @(posedge clock);
    endtask : rd
    task automatic pause(input int n);
        repeat (n) @(posedge clock);
    endtask : pause
    task automatic wait_flt(ref int cnt);
        int c0;
        c0 = cnt;
        repeat (600) if (cnt == c0) @(posedge clock);
        chk("fault_count", 8'h01, 8'(cnt - c0));
    endtask : wait_flt
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
    initial begin
        int i;
        int s;
        int k;
        int gap;
        int seen;
        clock = 1'b0;
        reset_n = 1'b0;
        undervoltage = 1'b0;
        address = 4'h0;
        write_data = 8'h00;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        lfsr_r = 32'h141d5a62;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        for (i = 0; i < 200 && link_if.reset_out_n !== 1'b1; i++) @(posedge clock);
        chk("powerup", 8'h01, 8'(i >= ST + DL - 1 && i <= ST + DL + 6));
        // the host's status synchroniser lags the pin by two cycles
        pause(2);
        rd("status", REG_STATUS, 8'h03);
        wr(REG_IRQ_ENABLE, 8'h03);
        rd("irq_status", REG_IRQ_STATUS, 8'h01);
        chk("irq", 8'h01, {7'h00, irq});
        wr(REG_IRQ_CLEAR, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        rd("unmapped", 4'hf, 8'h00);
        for (s = 0; s < 4; s++) begin
            wr(REG_CONTROL, 8'h02 | 8'(s << 2));
            wait_flt(n_late);
            pause(DL + 2);
            seen = n_early + n_late;
            for (k = 0; k < 3; k++) begin
                lfsr_r = lfsr_next(lfsr_r);
                gap = CW + 2 + int'(lfsr_r % 32'(open_len(s) - 10));
                // last kick lands near the end of the open window
                if (k == 2) gap = CW + open_len(s) - 8;
                pause(gap);
                wr(REG_CONTROL, 8'h03 | 8'(s << 2));
            end
            chk("no_fault", 8'(seen), 8'(n_early + n_late));
            pause(10);
            wr(REG_CONTROL, 8'h03 | 8'(s << 2));
            wait_flt(n_early);
            pause(4);
            rd("status", REG_STATUS, 8'h01);
            rd("irq_status", REG_IRQ_STATUS, 8'h02);
            wr(REG_IRQ_CLEAR, 8'h03);
        end
        wr(REG_CONTROL, 8'h00);
        pause(DL);
        wr(REG_CONTROL, 8'h10);
        pause(8);
        rd("status", REG_STATUS, 8'h02);
        pause(DL + 8);
        rd("status", REG_STATUS, 8'h03);
        rd("irq_status", REG_IRQ_STATUS, 8'h01);
        wr(REG_IRQ_CLEAR, 8'h01);
        undervoltage <= 1'b1;
        pause(12);
        rd("status", REG_STATUS, 8'h02);
        undervoltage <= 1'b0;
        pause(DL + 10);
        rd("status", REG_STATUS, 8'h03);
        give_verdict();
    end
endmodule : tb_window_watchdog_supervisor_timing
`default_nettype wire

/* File: verification/wwd_chk.sv */
// assertions on the link between host and supervisor
// assumes one clock; instantiated beside the link in the bench
`default_nettype none
module wwd_chk #(
    parameter int unsigned DELAY_CYCLES = 30,
    parameter int unsigned START_CYCLES = 10,
    parameter int unsigned UV_CYCLES = 5,
    parameter int unsigned KICK_CYCLES = 10,
    parameter int unsigned MR_CYCLES = 2
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic undervoltage,
    input wire logic kick_input,
    input wire logic watchdog_enable,
    input wire logic manual_reset_n,
    input wire logic reset_out_n,
    input wire logic fault_output_n,
    input wire logic early_fault,
    input wire logic late_fault
);
    localparam int D_LO = DELAY_CYCLES;
    localparam int F_LO = DELAY_CYCLES - 1;
    localparam int F_HI = DELAY_CYCLES + 1;
    localparam int P_LO = START_CYCLES + DELAY_CYCLES - 1;
    localparam int P_HI = START_CYCLES + DELAY_CYCLES + 6;
    localparam int UV_HI = UV_CYCLES + 4;
    localparam int K_LO = KICK_CYCLES;
    localparam int M_LO = MR_CYCLES;
    logic [15:0] flow_r;
    logic [15:0] rlow_r;
    logic [15:0] up_r;
    logic first_r;
    logic [15:0] klow_r;
    logic [15:0] mlow_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flow_r <= 16'h0000;
            rlow_r <= 16'h0000;
            up_r <= 16'h0000;
            first_r <= 1'b1;
            klow_r <= 16'h0000;
            mlow_r <= 16'h0000;
        end else begin
            flow_r <= fault_output_n ? 16'h0000 : flow_r + 16'h0001;
            rlow_r <= reset_out_n ? 16'h0000 : rlow_r + 16'h0001;
            up_r <= up_r + 16'h0001;
            first_r <= first_r & ~reset_out_n;
            klow_r <= kick_input ? 16'h0000 : klow_r + 16'h0001;
            mlow_r <= manual_reset_n ? 16'h0000 : mlow_r + 16'h0001;
        end
    end
    AST_POWERUP: assert property (first_r && reset_out_n |-> up_r inside {[P_LO:P_HI]})
        else $error("power-up release out of range");
    AST_MR_ASSERT: assert property ($fell(manual_reset_n) |-> ##[1:4] !reset_out_n)
        else $error("manual reset not asserted in time");
    AST_RESET_WIDTH: assert property ($rose(reset_out_n) |-> rlow_r >= D_LO)
        else $error("reset released early");
    AST_UV: assert property ($rose(undervoltage) |-> ##[1:UV_HI] !reset_out_n)
        else $error("undervoltage reset late");
    AST_FAULT_WIDTH: assert property ($rose(fault_output_n) && $past(reset_out_n)
        && reset_out_n |-> flow_r >= F_LO && flow_r <= F_HI)
        else $error("fault pulse width wrong");
    AST_FAULT_CAUSE: assert property (early_fault || late_fault |-> ##[1:3] !fault_output_n)
        else $error("fault output missing");
    AST_RESET_QUIET: assert property (!reset_out_n [*2] |-> fault_output_n)
        else $error("fault output during reset");
    AST_EARLY_KICK: assert property (early_fault |-> !kick_input && reset_out_n)
        else $error("early fault without kick");
    AST_LATE_NO_KICK: assert property (late_fault |-> kick_input && watchdog_enable)
        else $error("late fault with kick or disabled");
    AST_KICK_WIDTH: assert property ($rose(kick_input) |-> klow_r >= K_LO)
        else $error("kick pulse too short");
    AST_MR_WIDTH: assert property ($rose(manual_reset_n) |-> mlow_r >= M_LO)
        else $error("manual reset pulse too short");
    cover property (early_fault);
    cover property (late_fault);
    cover property ($rose(manual_reset_n));
    cover property ($rose(undervoltage));
endmodule : wwd_chk
`default_nettype wire

/* File: verilog/wwd_host.sv */
// host end: drives kick, enable, select and manual reset from registers
// assumes a plain register port; read data one cycle after read strobe
`default_nettype none
module wwd_host
    import wwd_pkg::*;
#(
    parameter int unsigned KICK_CYCLES = KICK_PULSE_CYCLES,
    parameter int unsigned MR_CYCLES = MR_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    wwd_link_if.host link,
    input wire logic [3:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    output logic irq
);
    logic [7:0] ctl_r;
    logic [1:0] rst_s_r, flt_s_r;
    logic rst_d_r, flt_d_r;
    logic [1:0] irq_st_r, irq_en_r;
    logic [7:0] kick_cnt_r, mr_cnt_r;

    wire wr_ctl = write_strobe & (address == REG_CONTROL);
    wire kick_req = wr_ctl & write_data[CTL_KICK] & (kick_cnt_r == 8'h00);
    wire mr_req = wr_ctl & write_data[CTL_MR] & (mr_cnt_r == 8'h00);
    wire rst_rise = rst_s_r[1] & ~rst_d_r;
    wire flt_fall = flt_d_r & ~flt_s_r[1];
    wire [1:0] irq_clr = (write_strobe & (address == REG_IRQ_CLEAR)) ? write_data[1:0] : 2'h0;
    wire [7:0] rd_mux = (address == REG_CONTROL) ? ctl_r :
                        (address == REG_STATUS) ? {6'h00, flt_s_r[1], rst_s_r[1]} :
                        (address == REG_IRQ_STATUS) ? {6'h00, irq_st_r} :
                        (address == REG_IRQ_ENABLE) ? {6'h00, irq_en_r} : 8'h00;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= CONTROL_RESET;
            kick_cnt_r <= 8'h00;
            mr_cnt_r <= 8'h00;
            rst_s_r <= 2'h0;
            flt_s_r <= 2'h3;
            rst_d_r <= 1'b0;
            flt_d_r <= 1'b1;
            irq_st_r <= 2'h0;
            irq_en_r <= 2'h0;
            read_data <= 8'h00;
        end else begin
            rst_s_r <= {rst_s_r[0], link.reset_out_n};
            flt_s_r <= {flt_s_r[0], link.fault_output_n};
            rst_d_r <= rst_s_r[1];
            flt_d_r <= flt_s_r[1];
            if (wr_ctl) begin
                ctl_r[CTL_ENABLE] <= write_data[CTL_ENABLE]; // [RULE2]
                ctl_r[CTL_SELECT +: SELECT_W] <= write_data[CTL_SELECT +: SELECT_W]; // [RULE3]
            end
            // kick is a low pulse held for its least width
            if (kick_req)
                kick_cnt_r <= 8'(KICK_CYCLES); // [RULE1]
            else if (kick_cnt_r != 8'h00)
                kick_cnt_r <= kick_cnt_r - 8'h01;
            if (mr_req)
                mr_cnt_r <= 8'(MR_CYCLES); // [RULE7]
            else if (mr_cnt_r != 8'h00)
                mr_cnt_r <= mr_cnt_r - 8'h01;
            if (write_strobe & (address == REG_IRQ_ENABLE))
                irq_en_r <= write_data[1:0];
            // set wins over clear
            irq_st_r <= (irq_st_r & ~irq_clr) | {flt_fall, rst_rise};
            read_data <= read_strobe ? rd_mux : 8'h00;
        end
    end

    assign link.kick_input = (kick_cnt_r == 8'h00);
    assign link.manual_reset_n = (mr_cnt_r == 8'h00);
    assign link.watchdog_enable = ctl_r[CTL_ENABLE];
    assign link.window_ratio_select = ctl_r[CTL_SELECT +: SELECT_W];
    assign irq = |(irq_st_r & irq_en_r);
endmodule : wwd_host
`default_nettype wire

/* File: verilog/wwd_link_if.sv */
// pin-level link between the host and the supervisor
// assumes both ends on the same clock
`default_nettype none
interface wwd_link_if;
    import wwd_pkg::*;
    logic kick_input;
    logic watchdog_enable;
    logic [SELECT_W-1:0] window_ratio_select;
    logic manual_reset_n;
    logic reset_out_n;
    logic fault_output_n;
    modport device (
        input kick_input,
        input watchdog_enable,
        input window_ratio_select,
        input manual_reset_n,
        output reset_out_n,
        output fault_output_n
    );
    modport host (
        output kick_input,
        output watchdog_enable,
        output window_ratio_select,
        output manual_reset_n,
        input reset_out_n,
        input fault_output_n
    );
endinterface : wwd_link_if
`default_nettype wire

/* File: verilog/wwd_pkg.sv */
// shared constants for the window watchdog supervisor and its host end
// assumes a single 20 MHz clock on both ends
`default_nettype none
package wwd_pkg;
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam int unsigned CLOCK_NS = 50;
    // host-side least times, in their own units
    localparam int unsigned KICK_PULSE_NS = 500;
    localparam int unsigned ENABLE_HOLD_US = 200;
    localparam int unsigned SELECT_HOLD_US = 150;
    localparam int unsigned MR_PULSE_NS = 100;
    localparam int unsigned KICK_PULSE_CYCLES = (KICK_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int unsigned MR_PULSE_CYCLES = (MR_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int unsigned ENABLE_HOLD_CYCLES = ENABLE_HOLD_US * (CLOCK_HZ / 1000000);
    localparam int unsigned SELECT_HOLD_CYCLES = SELECT_HOLD_US * (CLOCK_HZ / 1000000);
    // device-side longest times
    localparam int unsigned STARTUP_US = 500;
    localparam int unsigned UV_DETECT_US = 30;
    localparam int unsigned STARTUP_CYCLES = STARTUP_US * (CLOCK_HZ / 1000000);
    localparam int unsigned UV_DETECT_CYCLES = UV_DETECT_US * (CLOCK_HZ / 1000000);
    // factory options: closed window 1 ms, reset delay 2 ms
    localparam int unsigned CLOSED_WINDOW_US = 1000;
    localparam int unsigned RESET_DELAY_US = 2000;
    localparam int unsigned CLOSED_WINDOW_CYCLES = CLOSED_WINDOW_US * (CLOCK_HZ / 1000000);
    localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_US * (CLOCK_HZ / 1000000);
    localparam int unsigned TIMER_W = 32;
    localparam int unsigned SELECT_W = 2;
    // host register offsets (word index)
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h3;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // control bit positions
    localparam int unsigned CTL_KICK = 0;
    localparam int unsigned CTL_ENABLE = 1;
    localparam int unsigned CTL_SELECT = 2;
    localparam int unsigned CTL_MR = 4;
    // open-window multiplier n per select code
    function automatic logic [9:0] ratio_of(input logic [SELECT_W-1:0] sel);
        case (sel)
            2'h0: ratio_of = 10'h002;
            2'h1: ratio_of = 10'h004;
            2'h2: ratio_of = 10'h008;
            default: ratio_of = 10'h010;
        endcase
    endfunction : ratio_of
endpackage : wwd_pkg
`default_nettype wire

/* File: verilog/wwd_supervisor.sv */
// window watchdog supervisor timing core (device end)
// assumes reset_n is power-on; undervoltage arrives as a digital flag
// Functional notes
// RULE1: host holds kick at least 500 ns
// RULE2: host holds enable 200 us after change
// RULE3: host holds select 150 us after change
// RULE4: closed window from factory constant
// RULE5: open window is (n-1) closed windows
// RULE6: power-up release after startup plus reset delay
// RULE7: manual reset held low 100 ns
// RULE8: manual reset asserts reset promptly
// RULE9: reset delay after manual reset release
// RULE10: undervoltage asserts reset within 30 us
// RULE11: kick in closed window is early fault
// RULE12: open-window kick restarts; none is late fault
// RULE13: fault pulses fault output for reset delay
// RULE14: watchdog idle while reset held
// RULE15: one reset delay for all releases
// RULE16: inputs synchronised before use
//
// The register offsets and the address-and-strobe port were left to the implementer.
`default_nettype none
module wwd_supervisor
    import wwd_pkg::*;
#(
    parameter int unsigned CLOSED_CYCLES = CLOSED_WINDOW_CYCLES,
    parameter int unsigned DELAY_CYCLES = RESET_DELAY_CYCLES,
    parameter int unsigned START_CYCLES = STARTUP_CYCLES,
    parameter int unsigned UV_CYCLES = UV_DETECT_CYCLES,
    parameter int unsigned EN_HOLD_CYCLES = ENABLE_HOLD_CYCLES,
    parameter int unsigned SEL_HOLD_CYCLES = SELECT_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic undervoltage,
    wwd_link_if.device link,
    output logic early_fault,
    output logic late_fault
);
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_CLOSED = 2'b01,
        WD_OPEN = 2'b10
    } wd_state_type;

    logic [1:0] kick_s_r;
    logic [1:0] en_s_r;
    logic [1:0] mr_s_r;
    logic [1:0] uv_s_r;
    logic [SELECT_W-1:0] sel_a_r;
    logic [SELECT_W-1:0] sel_b_r;
    logic [SELECT_W-1:0] sel_r;
    logic [SELECT_W-1:0] sel_prev_r;
    logic kick_d_r;
    logic en_r;
    logic en_prev_r;
    logic [TIMER_W-1:0] en_cnt_r;
    logic [TIMER_W-1:0] sel_cnt_r;
    logic [TIMER_W-1:0] uv_cnt_r;
    logic [TIMER_W-1:0] rst_cnt_r;
    logic [TIMER_W-1:0] wd_cnt_r;
    logic [TIMER_W-1:0] flt_cnt_r;
    logic in_reset_r;
    logic started_r;
    logic fault_r;
    wd_state_type state_r;
    wd_state_type state_nxt;

    // a counter that started at zero has covered span cycles
    function automatic logic span_done(input logic [TIMER_W-1:0] count,
                                       input logic [TIMER_W-1:0] span);
        span_done = count >= span - TIMER_W'(1);
    endfunction : span_done

    function automatic logic [TIMER_W-1:0] bump(input logic [TIMER_W-1:0] count);
        bump = count + TIMER_W'(1);
    endfunction : bump

    // two-stage synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            kick_s_r <= 2'h3;
            en_s_r <= 2'h0;
            mr_s_r <= 2'h3;
            uv_s_r <= 2'h0;
            sel_a_r <= '0;
            sel_b_r <= '0;
        end else begin
            kick_s_r <= {kick_s_r[0], link.kick_input}; // [RULE16]
            en_s_r <= {en_s_r[0], link.watchdog_enable}; // [RULE16]
            mr_s_r <= {mr_s_r[0], link.manual_reset_n}; // [RULE16]
            uv_s_r <= {uv_s_r[0], undervoltage};
            sel_a_r <= link.window_ratio_select; // [RULE16]
            sel_b_r <= sel_a_r;
        end
    end

    // kick edge, reset causes and window ends
    wire kick = kick_s_r[1];
    wire kick_fall = kick_d_r & ~kick;
    wire mr_low = ~mr_s_r[1];
    wire uv_trip = uv_cnt_r >= TIMER_W'(UV_CYCLES - 2);
    wire hold_reset = mr_low | uv_trip;
    wire [TIMER_W-1:0] release_limit = started_r ? TIMER_W'(DELAY_CYCLES) :
                                       TIMER_W'(DELAY_CYCLES + START_CYCLES); // [RULE6] [RULE15]
    wire [TIMER_W-1:0] open_cycles = TIMER_W'(CLOSED_CYCLES) *
                                     TIMER_W'(ratio_of(sel_r) - 10'h001); // [RULE5]
    wire closed_done = span_done(wd_cnt_r, TIMER_W'(CLOSED_CYCLES)); // [RULE4]
    wire open_done = span_done(wd_cnt_r, open_cycles);
    wire en_settled = span_done(en_cnt_r, TIMER_W'(EN_HOLD_CYCLES));
    wire sel_settled = span_done(sel_cnt_r, TIMER_W'(SEL_HOLD_CYCLES));
    wire release_due = span_done(rst_cnt_r, release_limit);
    wire fault_over = span_done(flt_cnt_r, TIMER_W'(DELAY_CYCLES));
    wire watch = en_r & ~in_reset_r & ~fault_r;
    wire early = watch & (state_r == WD_CLOSED) & kick_fall; // [RULE11]
    wire late = watch & (state_r == WD_OPEN) & open_done & ~kick_fall; // [RULE12]

    // enable and select apply only after staying stable for their hold time
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            en_prev_r <= 1'b0;
            en_r <= 1'b0;
            en_cnt_r <= '0;
            sel_prev_r <= '0;
            sel_r <= '0;
            sel_cnt_r <= '0;
            kick_d_r <= 1'b1;
        end else begin
            kick_d_r <= kick;
            en_prev_r <= en_s_r[1];
            sel_prev_r <= sel_b_r;
            en_cnt_r <= (en_prev_r != en_s_r[1]) ? '0 : bump(en_cnt_r);
            if (en_settled)
                en_r <= en_prev_r; // [RULE2]
            sel_cnt_r <= (sel_prev_r != sel_b_r) ? '0 : bump(sel_cnt_r);
            if (sel_settled)
                sel_r <= sel_prev_r; // [RULE3]
        end
    end

    // supervisor reset timing
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            uv_cnt_r <= '0;
            rst_cnt_r <= '0;
            in_reset_r <= 1'b1;
            started_r <= 1'b0;
        end else begin
            if (!uv_s_r[1])
                uv_cnt_r <= '0;
            else if (!uv_trip)
                uv_cnt_r <= bump(uv_cnt_r); // [RULE10]
            if (hold_reset) begin
                in_reset_r <= 1'b1; // [RULE8]
                rst_cnt_r <= '0;
            end else if (in_reset_r) begin
                if (release_due) begin
                    in_reset_r <= 1'b0; // [RULE9]
                    started_r <= 1'b1;
                end else begin
                    rst_cnt_r <= bump(rst_cnt_r);
                end
            end
        end
    end

    // frame state: closed window, then open window
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WD_IDLE: state_nxt = watch ? WD_CLOSED : WD_IDLE;
            WD_CLOSED: state_nxt = (early | ~watch) ? WD_IDLE :
                                   (closed_done ? WD_OPEN : WD_CLOSED);
            WD_OPEN: state_nxt = (~watch | late) ? WD_IDLE :
                                 (kick_fall ? WD_CLOSED : WD_OPEN); // [RULE12]
            default: state_nxt = WD_IDLE;
        endcase
    end

    // frame timer and fault pulse
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= WD_IDLE;
            wd_cnt_r <= '0;
            fault_r <= 1'b0;
            flt_cnt_r <= '0;
            early_fault <= 1'b0;
            late_fault <= 1'b0;
        end else begin
            state_r <= state_nxt;
            early_fault <= early;
            late_fault <= late;
            wd_cnt_r <= (state_nxt != state_r) ? '0 : bump(wd_cnt_r);
            if (in_reset_r) begin
                fault_r <= 1'b0; // [RULE14]
                flt_cnt_r <= '0;
            end else if (early | late) begin
                fault_r <= 1'b1; // [RULE13]
                flt_cnt_r <= '0;
            end else if (fault_r) begin
                if (fault_over)
                    fault_r <= 1'b0; // [RULE15]
                else
                    flt_cnt_r <= bump(flt_cnt_r);
            end
        end
    end

    assign link.reset_out_n = ~in_reset_r;
    assign link.fault_output_n = ~fault_r;
endmodule : wwd_supervisor
`default_nettype wire
